// File: inc/esr_params.svh
/*
  Constants for the erase, suspend and resume sequencer: opcodes, flag
  positions, register offsets, frame lengths and default cycle counts.
  Assumes inclusion by bare name from every file that needs a figure.
*/
`ifndef ESR_PARAMS_SVH
`define ESR_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Opcodes
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_CLRFS 8'h50
`define OP_SSE_A 8'h52
`define OP_SSE_B 8'h20
`define OP_SE 8'hD8
`define OP_BE_A 8'hC7
`define OP_BE_B 8'h60
`define OP_SUSP 8'h75
`define OP_RES 8'h7A
`define OP_PP 8'h02
`define OP_RDSR 8'h05
`define OP_RDFS 8'h70

////////////////////////////////////////////////////////////////////////////
// Flag status bits and reset value
`define FS_RESET 8'h80
`define FS_READY 7
`define FS_ESUS 6
`define FS_EERR 5
`define FS_PERR 4
`define FS_PSUS 2
`define FS_PROT 1

////////////////////////////////////////////////////////////////////////////
// Frame lengths in bytes
`define LEN_CMD 3'h1
`define LEN_ADDR 3'h4
`define LEN_PROG 3'h5
`define LEN_SAT 3'h7

////////////////////////////////////////////////////////////////////////////
// Array geometry
`define NSUB 256
`define NSEC 16
`define ADDR_SUB_MSB 19
`define ADDR_SUB_LSB 12
`define SEC_MSB 7
`define SEC_LSB 4

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define REG_STATUS 5'h00
`define REG_LOCK 5'h04
`define REG_BSEL 5'h08
`define REG_BLANK 5'h0C
`define REG_CTRL 5'h10

////////////////////////////////////////////////////////////////////////////
// Default cycle counts at the system clock
`define DEF_SSE_CYC 16'h0190
`define DEF_SE_CYC 16'h0640
`define DEF_BE_CYC 16'h1900
`define DEF_PP_CYC 16'h00C8
`define DEF_LAT_CYC 16'h0028
`define DEF_TOUT_CYC 16'h4E20

`endif

// File: inc/esr_pkg.sv
/*
  Types shared by the sequencer files: bus request, frame events, erase
  kind and the sequencer state. Assumes nothing of its surroundings.
*/
package esr_pkg;

  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic byte_valid;
    logic aligned;
    logic [7:0] data;
  } frame_t;

  typedef enum logic [1:0] {K_SUB, K_SEC, K_BULK} erase_kind_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_SUSPENDING} st_t;

endpackage : esr_pkg

// File: logic/op_timer.sv
/*
  Elapsed-time counter for one self-timed array operation.
  Assumes start is a one-cycle pulse and run is held while it may advance.
*/
`timescale 1ns/10ps
module op_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic run,
  input wire logic slow,
  input wire logic [15:0] duration,
  input wire logic [15:0] limit,
  output logic done,
  output logic tout
);
  import esr_pkg::*;

  logic [15:0] elapsed;

  // Held while paused, so a resume continues where it stopped
  always_ff @(posedge clk) begin
    if (rst || start) begin
      elapsed <= 16'h0000;
    end else if (run) begin
      elapsed <= elapsed + 16'h0001;
    end
  end

  assign done = run && !slow && (elapsed == duration - 16'h0001);
  assign tout = run && !done && (elapsed == limit - 16'h0001);

endmodule : op_timer

// File: logic/serial_frontend.sv
/*
  Serial pin front end: synchronises clock, select and data, frames
  bytes and shifts a status byte out on lane 1.
  Assumes the serial clock is far slower than the system clock.
*/
`timescale 1ns/10ps
module serial_frontend (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic din,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  output esr_pkg::frame_t frame,
  output logic dout,
  output logic doe
);
  import esr_pkg::*;

  logic [2:0] sclk_s;
  logic [2:0] sel_s;
  logic [1:0] din_s;
  logic [2:0] bit_cnt;
  logic [2:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] tx_sh;
  logic tx_on;
  logic rise;
  logic fall;
  logic sel_low;

  ////////////////////////////////////////////////////////////////////////
  // Only stages 1 and 2 are looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s <= 3'h0;
      sel_s <= 3'h7;
      din_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      sel_s <= {sel_s[1:0], sel_n};
      din_s <= {din_s[0], din};
    end
  end

  assign rise = sclk_s[1] && !sclk_s[2];
  assign fall = !sclk_s[1] && sclk_s[2];
  assign sel_low = !sel_s[1] && !sel_s[2];
  assign next_cnt = (sel_low && rise) ? bit_cnt + 3'h1 : bit_cnt;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      frame <= '0;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
    end else begin
      frame.start <= !sel_s[1] && sel_s[2];
      frame.stop <= sel_s[1] && !sel_s[2];
      frame.byte_valid <= 1'b0;
      frame.aligned <= (next_cnt == 3'h0);
      if (!sel_s[1] && sel_s[2]) begin
        bit_cnt <= 3'h0;
      end else if (sel_low && rise) begin
        shift <= {shift[6:0], din_s[1]};
        bit_cnt <= next_cnt;
        if (bit_cnt == 3'h7) begin
          frame.byte_valid <= 1'b1;
          frame.data <= {shift[6:0], din_s[1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output changes on the falling edge so the host samples on the rise
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sh <= 8'h00;
      tx_on <= 1'b0;
      dout <= 1'b0;
      doe <= 1'b0;
    end else if (sel_s[1]) begin
      tx_on <= 1'b0;
      doe <= 1'b0;
    end else if (tx_load) begin
      tx_sh <= tx_byte;
      tx_on <= 1'b1;
    end else if (tx_on && fall) begin
      dout <= tx_sh[7];
      tx_sh <= {tx_sh[6:0], 1'b0};
      doe <= 1'b1;
    end
  end

endmodule : serial_frontend

// File: logic/erase_suspend_resume_control.sv
/*
  Erase, suspend and resume sequencer of a serial NOR flash, with a
  blank map per subsector, sector locks and an Avalon-MM slave.
  Assumes SCLK, SEL_N and the lanes come from pins of another domain and
  the serial clock runs well below a quarter of CLK_SYS.
*/
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`include "esr_params.svh"
module erase_suspend_resume_control #(
  parameter logic [15:0] SSE_CYC = `DEF_SSE_CYC,
  parameter logic [15:0] SE_CYC = `DEF_SE_CYC,
  parameter logic [15:0] BE_CYC = `DEF_BE_CYC,
  parameter logic [15:0] PP_CYC = `DEF_PP_CYC,
  parameter logic [15:0] LAT_CYC = `DEF_LAT_CYC,
  parameter logic [15:0] TOUT_CYC = `DEF_TOUT_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire esr_pkg::av_req_t AV_REQ,
  output logic [31:0] AV_READDATA,
  output logic AV_WAITREQUEST,
  input wire logic SCLK,
  input wire logic SEL_N,
  input wire logic [3:0] SERIAL_IO_LANES_IN,
  output logic [3:0] SERIAL_IO_LANES_OUT,
  output logic [3:0] SERIAL_IO_LANES_OE
);
  import esr_pkg::*;

  frame_t frame;
  st_t st;
  erase_kind_t ekind;
  logic [7:0] fs;
  logic wel;
  logic wip;
  logic erase_held;
  logic prog_held;
  logic susp_prog;
  logic [15:0] lat_cnt;
  logic [7:0] esub;
  logic [7:0] psub;
  logic [7:0] cmd;
  logic [2:0] nbytes;
  logic [23:0] addr;
  logic [15:0] lock;
  logic [7:0] bsel;
  logic slow;
  logic [`NSUB-1:0] blank;
  logic e_start;
  logic p_start;
  logic e_done;
  logic e_tout;
  logic p_done;
  logic p_tout;
  logic tx_load;
  logic [7:0] tx_byte;
  logic dout;
  logic doe;
  logic [31:0] rd_word;
  logic [7:0] rd_cmd;
  logic [7:0] sub_sel;
  logic [15:0] e_dur;
  logic exec;
  logic run_erase;
  logic run_prog;
  logic cur_done;
  logic cur_tout;
  logic erase_blocked;
  logic erase_ok;
  logic erase_fin;
  logic prog_fin;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic is_erase(input logic [7:0] op);
    is_erase = (op == `OP_SSE_A) || (op == `OP_SSE_B) || (op == `OP_SE) ||
               (op == `OP_BE_A) || (op == `OP_BE_B);
  endfunction : is_erase

  function automatic erase_kind_t kind_of(input logic [7:0] op);
    if ((op == `OP_BE_A) || (op == `OP_BE_B)) begin
      kind_of = K_BULK;
    end else if (op == `OP_SE) begin
      kind_of = K_SEC;
    end else begin
      kind_of = K_SUB;
    end
  endfunction : kind_of

  function automatic logic [2:0] erase_len(input logic [7:0] op);
    erase_len = (kind_of(op) == K_BULK) ? `LEN_CMD : `LEN_ADDR;
  endfunction : erase_len

  function automatic logic [3:0] sec_of(input logic [7:0] s);
    sec_of = s[`SEC_MSB:`SEC_LSB];
  endfunction : sec_of

  ////////////////////////////////////////////////////////////////////////
  // Pins and timers
  serial_frontend u_front (
    .clk(CLK_SYS),
    .rst(RST),
    .sclk(SCLK),
    .sel_n(SEL_N),
    .din(SERIAL_IO_LANES_IN[0]),
    .tx_load(tx_load),
    .tx_byte(tx_byte),
    .frame(frame),
    .dout(dout),
    .doe(doe)
  );

  op_timer u_etimer (
    .clk(CLK_SYS),
    .rst(RST),
    .start(e_start),
    .run(run_erase),
    .slow(slow),
    .duration(e_dur),
    .limit(TOUT_CYC),
    .done(e_done),
    .tout(e_tout)
  );

  op_timer u_ptimer (
    .clk(CLK_SYS),
    .rst(RST),
    .start(p_start),
    .run(run_prog),
    .slow(slow),
    .duration(PP_CYC),
    .limit(TOUT_CYC),
    .done(p_done),
    .tout(p_tout)
  );

  // Straight from the front end flops; another stage misses the next rise
  assign SERIAL_IO_LANES_OUT = {2'h0, dout, 1'h0};
  assign SERIAL_IO_LANES_OE = {2'h0, doe, 1'h0};

  ////////////////////////////////////////////////////////////////////////
  // Frame collection
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cmd <= 8'h00;
      nbytes <= 3'h0;
      addr <= 24'h000000;
      tx_load <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      tx_load <= frame.byte_valid &&
                 ((rd_cmd == `OP_RDFS) || (rd_cmd == `OP_RDSR));
      tx_byte <= (rd_cmd == `OP_RDFS) ? fs : {6'h00, wel, wip};
      if (frame.start) begin
        nbytes <= 3'h0;
      end else if (frame.byte_valid) begin
        if (nbytes == 3'h0) begin
          cmd <= frame.data;
        end else if (nbytes < `LEN_ADDR) begin
          addr <= {addr[15:0], frame.data};
        end
        if (nbytes != `LEN_SAT) begin
          nbytes <= nbytes + 3'h1;
        end
      end
    end
  end

  assign rd_cmd = (nbytes == 3'h0) ? frame.data : cmd;
  assign sub_sel = addr[`ADDR_SUB_MSB:`ADDR_SUB_LSB];
  assign exec = frame.stop && frame.aligned;
  assign run_erase = (st == ST_ERASE) || ((st == ST_SUSPENDING) && !susp_prog);
  assign run_prog = (st == ST_PROG) || ((st == ST_SUSPENDING) && susp_prog);
  assign cur_done = (run_erase && e_done) || (run_prog && p_done);
  assign cur_tout = (run_erase && e_tout) || (run_prog && p_tout);
  assign erase_fin = run_erase && e_done;
  assign prog_fin = run_prog && p_done;
  assign erase_blocked = (kind_of(cmd) == K_BULK) ? |lock :
                         lock[sec_of(sub_sel)];
  assign erase_ok = is_erase(cmd) && wel && !erase_held && !prog_held &&
                    (nbytes == erase_len(cmd));
  assign e_dur = (ekind == K_BULK) ? BE_CYC :
                 (ekind == K_SEC) ? SE_CYC : SSE_CYC;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer; later assignments win, so error sets beat a clear
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st <= ST_IDLE;
      fs <= `FS_RESET;
      wel <= 1'b0;
      wip <= 1'b0;
      erase_held <= 1'b0;
      prog_held <= 1'b0;
      susp_prog <= 1'b0;
      lat_cnt <= 16'h0000;
      ekind <= K_SUB;
      esub <= 8'h00;
      psub <= 8'h00;
      e_start <= 1'b0;
      p_start <= 1'b0;
    end else begin
      e_start <= 1'b0;
      p_start <= 1'b0;
      if (exec && (cmd == `OP_CLRFS) && (nbytes == `LEN_CMD)) begin
        fs[`FS_EERR] <= 1'b0;
        fs[`FS_PERR] <= 1'b0;
        fs[`FS_PROT] <= 1'b0;
      end
      case (st)
        ST_IDLE: begin
          if (exec && (nbytes == `LEN_CMD) && (cmd == `OP_WREN)) begin
            wel <= 1'b1;
          end else if (exec && (nbytes == `LEN_CMD) && (cmd == `OP_WRDI)) begin
            wel <= 1'b0;
          end else if (exec && erase_ok) begin
            if (erase_blocked) begin
              fs[`FS_PROT] <= 1'b1;
              fs[`FS_EERR] <= 1'b1;
            end else begin
              st <= ST_ERASE;
              wip <= 1'b1;
              fs[`FS_READY] <= 1'b0;
              ekind <= kind_of(cmd);
              esub <= sub_sel;
              e_start <= 1'b1;
            end
          end else if (exec && (cmd == `OP_PP) && wel && !prog_held &&
                       (nbytes >= `LEN_PROG)) begin
            if (erase_held && (sec_of(sub_sel) == sec_of(esub))) begin
              fs[`FS_PERR] <= 1'b1;
            end else if (lock[sec_of(sub_sel)]) begin
              fs[`FS_PROT] <= 1'b1;
              fs[`FS_PERR] <= 1'b1;
            end else begin
              st <= ST_PROG;
              wip <= 1'b1;
              fs[`FS_READY] <= 1'b0;
              psub <= sub_sel;
              p_start <= 1'b1;
            end
          end else if (exec && (cmd == `OP_RES) && (nbytes == `LEN_CMD)) begin
            if (prog_held) begin
              prog_held <= 1'b0;
              st <= ST_PROG;
              wip <= 1'b1;
              fs[`FS_READY] <= 1'b0;
              fs[`FS_PSUS] <= 1'b0;
            end else if (erase_held) begin
              erase_held <= 1'b0;
              st <= ST_ERASE;
              wip <= 1'b1;
              fs[`FS_READY] <= 1'b0;
              fs[`FS_ESUS] <= 1'b0;
            end
          end
        end
        ST_ERASE, ST_PROG, ST_SUSPENDING: begin
          if (cur_done || cur_tout) begin
            st <= ST_IDLE;
            wip <= 1'b0;
            wel <= 1'b0;
            fs[`FS_READY] <= 1'b1;
            if (st == ST_SUSPENDING) begin
              fs[susp_prog ? `FS_PSUS : `FS_ESUS] <= 1'b0;
            end
            if (cur_tout) begin
              fs[run_prog ? `FS_PERR : `FS_EERR] <= 1'b1;
            end
          end else if (st == ST_SUSPENDING) begin
            if (lat_cnt == LAT_CYC - 16'h0001) begin
              st <= ST_IDLE;
              wip <= 1'b0;
              fs[`FS_READY] <= 1'b1;
              if (susp_prog) begin
                prog_held <= 1'b1;
              end else begin
                erase_held <= 1'b1;
              end
            end else begin
              lat_cnt <= lat_cnt + 16'h0001;
            end
          end else if (exec && (cmd == `OP_SUSP) && (nbytes == `LEN_CMD)) begin
            st <= ST_SUSPENDING;
            susp_prog <= (st == ST_PROG);
            lat_cnt <= 16'h0000;
            fs[(st == ST_PROG) ? `FS_PSUS : `FS_ESUS] <= 1'b1;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Blank map, one bit per subsector; stands in for the cell array
  for (genvar i = 0; i < `NSUB; i++) begin : g_blank
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        blank[i] <= 1'b0;
      end else if (erase_fin && ((ekind == K_BULK) ||
                   ((ekind == K_SEC) && (sec_of(8'(i)) == sec_of(esub))) ||
                   ((ekind == K_SUB) && (8'(i) == esub)))) begin
        blank[i] <= 1'b1;
      end else if (prog_fin && (8'(i) == psub)) begin
        blank[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: answers one cycle after the request
  always_comb begin
    rd_word = 32'h00000000;
    case (AV_REQ.address)
      `REG_STATUS: rd_word = {16'h0000, fs, 6'h00, wel, wip};
      `REG_LOCK: rd_word = {16'h0000, lock};
      `REG_BSEL: rd_word = {24'h000000, bsel};
      `REG_BLANK: rd_word = {31'h00000000, blank[bsel]};
      `REG_CTRL: rd_word = {31'h00000000, slow};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      AV_WAITREQUEST <= 1'b1;
      AV_READDATA <= 32'h00000000;
      lock <= 16'h0000;
      bsel <= 8'h00;
      slow <= 1'b0;
    end else begin
      AV_WAITREQUEST <= !((AV_REQ.read || AV_REQ.write) && AV_WAITREQUEST);
      if (AV_REQ.read && AV_WAITREQUEST) begin
        AV_READDATA <= rd_word;
      end
      if (AV_REQ.write && !AV_WAITREQUEST) begin
        if ((AV_REQ.address == `REG_LOCK) && AV_REQ.byteenable[0]) begin
          lock[7:0] <= AV_REQ.writedata[7:0];
        end
        if ((AV_REQ.address == `REG_LOCK) && AV_REQ.byteenable[1]) begin
          lock[15:8] <= AV_REQ.writedata[15:8];
        end
        if ((AV_REQ.address == `REG_BSEL) && AV_REQ.byteenable[0]) begin
          bsel <= AV_REQ.writedata[7:0];
        end
        if ((AV_REQ.address == `REG_CTRL) && AV_REQ.byteenable[0]) begin
          slow <= AV_REQ.writedata[0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_erase_busy: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st == ST_ERASE) |-> (wip && !fs[`FS_READY]))
    else $error("erase running without busy flags");

  a_no_wel_ignore: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((st == ST_IDLE) && exec && is_erase(cmd) && !wel) |=>
    ((st == ST_IDLE) && $stable(fs)))
    else $error("erase without write enable acted");

  a_unaligned_stop: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((st == ST_IDLE) && frame.stop && !frame.aligned) |=>
    ((st == ST_IDLE) && $stable(wel) && $stable(fs)))
    else $error("unaligned frame executed");

  a_protect_flags: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((st == ST_IDLE) && exec && erase_ok && erase_blocked) |=>
    (fs[`FS_PROT] && fs[`FS_EERR] && wel && (st == ST_IDLE)))
    else $error("protected erase not refused");

  a_end_clears: assert property (@(posedge CLK_SYS) disable iff (RST)
    (cur_done || cur_tout) |=> (!wel && !wip && fs[`FS_READY]))
    else $error("operation end left enable or busy");

  a_timeout_flag: assert property (@(posedge CLK_SYS) disable iff (RST)
    (run_erase && e_tout) |=> (fs[`FS_EERR] && !wel))
    else $error("erase timeout not flagged");

  a_suspend_bit: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((st == ST_ERASE) && !cur_done && !cur_tout && exec &&
     (cmd == `OP_SUSP) && (nbytes == `LEN_CMD)) |=>
    (fs[`FS_ESUS] && (st == ST_SUSPENDING) && !fs[`FS_READY]))
    else $error("erase suspend bit not set");

  a_suspend_ready: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((st == ST_SUSPENDING) && !cur_done && !cur_tout &&
     (lat_cnt == LAT_CYC - 16'h0001)) |=>
    (fs[`FS_READY] && (st == ST_IDLE) && (erase_held || prog_held)))
    else $error("suspend did not reach ready");

  a_late_finish: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((st == ST_SUSPENDING) && !susp_prog && e_done) |=>
    (!fs[`FS_ESUS] && !erase_held))
    else $error("finished erase left suspend bit");

  a_nest_order: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((st == ST_IDLE) && prog_held && erase_held && exec &&
     (cmd == `OP_RES) && (nbytes == `LEN_CMD)) |=>
    ((st == ST_PROG) && erase_held && !prog_held))
    else $error("nested resume out of order");

  a_resume_none: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((st == ST_IDLE) && !prog_held && !erase_held && exec &&
     (cmd == `OP_RES)) |=> ((st == ST_IDLE) && !wip))
    else $error("resume with nothing suspended acted");

  a_susp_sector: assert property (@(posedge CLK_SYS) disable iff (RST)
    ((st == ST_IDLE) && exec && (cmd == `OP_PP) && wel && erase_held &&
     !prog_held && (nbytes >= `LEN_PROG) &&
     (sec_of(sub_sel) == sec_of(esub))) |=>
    (fs[`FS_PERR] && wel && (st == ST_IDLE)))
    else $error("program into suspended sector ran");

  a_bulk_fill: assert property (@(posedge CLK_SYS) disable iff (RST)
    (erase_fin && (ekind == K_BULK)) |=> (&blank))
    else $error("bulk erase left cells");

endmodule : erase_suspend_resume_control

// File: tb/host_spi_model.sv
/* Host serial controller model: frames bits on lane 0, samples lane 1.
   Assumes the bench clock; one link bit spans 8 bench cycles. */
`timescale 1ns/10ps
module host_spi_model (
  input wire logic clk,
  output logic sclk,
  output logic sel_n,
  output logic mosi,
  input wire logic miso
);
  logic [7:0] rx = 8'h00;
  initial sclk = 1'b0;
  initial sel_n = 1'b1;
  initial mosi = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // Link clock stands still between frames
  task automatic frame(input logic [63:0] d, input int n);
    @(posedge clk) sel_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi <= d[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      rx <= {rx[6:0], miso};
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    @(posedge clk) sel_n <= 1'b1;
    mosi <= ~mosi;
    repeat (10) @(posedge clk);
  endtask : frame
endmodule : host_spi_model

// File: tb/erase_suspend_resume_control_tb_top.sv
/* Bench of the erase, suspend and resume sequencer.
   Assumes host_spi_model on the link and shortened cycle counts. */
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  miscompares++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module erase_suspend_resume_control_tb_top;
  import esr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  av_req_t req = '0;
  logic [31:0] rd;
  logic [31:0] got;
  logic wr;
  logic [3:0] lo;
  logic [3:0] oe;
  wire logic sclk;
  wire logic sel_n;
  wire logic mosi;
  int miscompares = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  host_spi_model host_spi_model_i (.clk(clk), .sclk(sclk), .sel_n(sel_n),
    .mosi(mosi), .miso(oe[1] ? lo[1] : ~lo[1]));
  erase_suspend_resume_control #(.SSE_CYC(16'h00C8),
    .BE_CYC(16'h0190), .LAT_CYC(16'h0008),
    .TOUT_CYC(16'h07D0)) erase_suspend_resume_control_i (.CLK_SYS(clk),
    .RST(rst), .AV_REQ(req), .AV_READDATA(rd), .AV_WAITREQUEST(wr),
    .SCLK(sclk), .SEL_N(sel_n), .SERIAL_IO_LANES_IN({3'h0, mosi}),
    .SERIAL_IO_LANES_OUT(lo), .SERIAL_IO_LANES_OE(oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{read: ~w, write: w, address: a, byteenable: 4'hF, writedata: d};
    do @(posedge clk); while (wr !== 1'b0);
    got = rd;
    req <= '0;
  endtask : av
  task automatic st(input logic [31:0] e, input logic [31:0] m);
    av(1'b0, 5'h00, '0);
    `CHK(got & m, e)
  endtask : st
  task automatic cmd(input logic [7:0] op);
    host_spi_model_i.frame({24'h0, op}, 8);
  endtask : cmd
  ////////////////////////////////////////////////////////////////////////
  task automatic t_erase;
    st(32'h8000, 32'hFFFF);
    av(1'b0, 5'h14, '0);
    `CHK(got, 32'h0)
    host_spi_model_i.frame({8'h20, 24'h035ABC}, 32);
    st(32'h8000, 32'hFFFF);
    cmd(8'h06);
    host_spi_model_i.frame({8'h20, 24'h035ABC} >> 1, 31);
    st(32'h8002, 32'hFFFF);
    host_spi_model_i.frame({8'h20, 24'h035ABC}, 32);
    st(32'h0001, 32'hFF01);
    repeat (250) @(posedge clk);
    st(32'h8000, 32'hFFFF);
    av(1'b1, 5'h08, 32'h35);
    av(1'b0, 5'h0C, '0);
    `CHK(got[0], 1'b1)
  endtask : t_erase
  // Lock of sector 3 guards both the sector and the whole array
  task automatic t_prot;
    av(1'b1, 5'h04, 32'h8);
    cmd(8'h06);
    host_spi_model_i.frame({8'hD8, 24'h03FFFF}, 32);
    st(32'hA202, 32'hFFFF);
    cmd(8'h50);
    cmd(8'hC7);
    st(32'hA202, 32'hFFFF);
    cmd(8'h50);
    st(32'h8002, 32'hFFFF);
    av(1'b1, 5'h04, '0);
    av(1'b1, 5'h10, 32'h1);
    cmd(8'h60);
    repeat (2100) @(posedge clk);
    st(32'hA000, 32'hFFFF);
    av(1'b1, 5'h10, '0);
    cmd(8'h50);
  endtask : t_prot
  task automatic t_susp;
    cmd(8'h06);
    host_spi_model_i.frame({8'h52, 24'h010000}, 32);
    cmd(8'h75);
    repeat (10) @(posedge clk);
    st(32'hC000, 32'hFF01);
    host_spi_model_i.frame({8'h70, 16'h0}, 24);
    `CHK(host_spi_model_i.rx, 8'hC0)
    cmd(8'h7A);
    st(32'h0001, 32'hFF01);
    repeat (250) @(posedge clk);
    st(32'h8000, 32'hFFFF);
    cmd(8'h7A);
    st(32'h8000, 32'hFFFF);
  endtask : t_susp
  // Erase in sector 2 held, program in sector 5 nested inside it
  task automatic t_nest;
    cmd(8'h06);
    host_spi_model_i.frame({8'h52, 24'h020000}, 32);
    cmd(8'h75);
    repeat (10) @(posedge clk);
    av(1'b1, 5'h04, 32'h4);
    host_spi_model_i.frame({8'h02, 24'h02F000, 8'h00}, 40);
    st(32'hD002, 32'hFFFF);
    cmd(8'h50);
    host_spi_model_i.frame({8'h02, 24'h050000, 8'hA5}, 40);
    cmd(8'h75);
    repeat (10) @(posedge clk);
    st(32'hC402, 32'hFFFF);
    cmd(8'h7A);
    st(32'h4001, 32'hFF01);
    repeat (250) @(posedge clk);
    st(32'hC000, 32'hFFFF);
    cmd(8'h7A);
    repeat (250) @(posedge clk);
    av(1'b1, 5'h08, 32'h20);
    av(1'b0, 5'h0C, '0);
    `CHK(got[0], 1'b1)
    av(1'b1, 5'h04, '0);
  endtask : t_nest
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_erase;
    t_prot;
    t_susp;
    t_nest;
    conclude;
  end
  initial begin
    #(25 * 20000);
    miscompares++;
    conclude;
  end
endmodule : erase_suspend_resume_control_tb_top
